// >>> inc/can_buf_pkg.sv
/*
  Constants and types for the CAN message buffering block.
  Assumes one 100 MHz module clock shared with the protocol engine.
*/
package can_buf_pkg;

  localparam int ID_W    = 29;
  localparam int DATA_W  = 64;
  localparam int DLC_W   = 4;
  localparam int ENTRY_W = 1 + DLC_W + ID_W + DATA_W;
  localparam int N_FILT  = 6;
  localparam int N_FILT0 = 2;
  localparam int N_RXB   = 2;
  localparam int N_TXB   = 3;
  localparam int TXB_AW  = 2;
  localparam int TXB_BYTES  = 14;
  localparam int TXB_DATA_B = 8;

  // Standard identifier sits in the top 11 identifier bits
  localparam logic [ID_W-1:0] STD_ID_CARE = 29'h1FFC0000;

  localparam logic [7:0] RX_WARN_LIMIT = 8'h60;
  localparam logic [7:0] RX_PASS_LIMIT = 8'h7F;
  localparam logic [8:0] TX_WARN_LIMIT = 9'h060;
  localparam logic [8:0] TX_PASS_LIMIT = 9'h07F;
  localparam logic [8:0] TX_BOFF_LIMIT = 9'h0FF;
  localparam logic [7:0] RX_CNT_MAX    = 8'hFF;
  localparam logic [8:0] TX_CNT_MAX    = 9'h1FF;

  localparam logic [7:0] RX_CNT_RST = 8'h00;
  localparam logic [8:0] TX_CNT_RST = 9'h000;

  typedef enum logic {T_IDLE, T_BUSY} tx_state_e;

endpackage

// >>> rtl/can_msg_ram.sv
/*
  Small buffer memory with one write port and a registered read port.
  Assumes the caller keeps addresses below the depth.
*/
`timescale 1ns/1ps
module can_msg_ram #(
  parameter int W  = 8,
  parameter int D  = 2,
  parameter int AW = 1
) (
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic          clk_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);

  logic [W-1:0] mem [D];
  logic [W-1:0] rd_data_ff;
  logic [W-1:0] nxt_rd_data;

  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (rd_en) begin
      nxt_rd_data = mem[rd_addr];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_data_ff <= '0;
    end else if (clk_en) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

endmodule

// >>> rtl/can_msg_buffer.sv
/*
  Receive and transmit message buffering for a CAN controller.
  Assumes the protocol engine runs on clk_sys and gives one-cycle pulses;
  software-side controls are plain ports on the same clock.
*/
`timescale 1ns/1ps
// Summary of operation
// - Assembly buffer feeds two visible receive buffers
// - Store sets receive flag; software clears it
// - Filters 0-1 to buffer 0, 2-5 to 1
// - Frame format selects which filters compare
// - Zero mask bit always matches
// - Full target: overrun and summary error, discard
// - Without double buffering, no redirect, overrun zero
// - Double buffering redirects to buffer one
// - Receive errors count; warning at 96
// - Receive interrupt right after stored frame
// - Receive error sets invalid-message flag
// - Receive count above 127 sets passive
// - Three transmit buffers, 14 bytes each
// - Highest priority pending buffer sent first
// - Request set clears abort, arbitration, error flags
// - Success clears request, may interrupt
// - Failure keeps request, sets error or arbitration
// - Clear request or abort-all aborts idle buffers
// - Transmit errors count; warning above 96
// - Transmit interrupt while a done buffer has no request
// - Transmit count above 127 sets passive
// - Transmit count above 255 sets bus-off
module can_msg_buffer import can_buf_pkg::*; (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   rx_frame_valid,
  input  wire logic [ID_W-1:0]        rx_id,
  input  wire logic                   received_ext_id_bit,
  input  wire logic [DLC_W-1:0]       rx_dlc,
  input  wire logic [DATA_W-1:0]      rx_data,
  input  wire logic                   rx_err_crc,
  input  wire logic                   rx_err_stuff,
  input  wire logic                   rx_err_invalid,
  input  wire logic [N_FILT*ID_W-1:0] accept_filter_id,
  input  wire logic [N_FILT-1:0]      filter_ext_select,
  input  wire logic [ID_W-1:0]        accept_mask_zero,
  input  wire logic [ID_W-1:0]        accept_mask_one,
  input  wire logic                   double_buffer_enable,
  input  wire logic [N_RXB-1:0]       receive_irq_enable,
  input  wire logic [N_RXB-1:0]       receive_done_clear,
  input  wire logic [N_RXB-1:0]       overrun_clear,
  input  wire logic                   error_flag_clear,
  input  wire logic                   rd_req,
  input  wire logic                   rd_sel,
  output logic      [ID_W-1:0]        rd_id,
  output logic                        rd_ext,
  output logic      [DLC_W-1:0]       rd_dlc,
  output logic      [DATA_W-1:0]      rd_data,
  input  wire logic                   tx_load,
  input  wire logic [TXB_AW-1:0]      tx_load_sel,
  input  wire logic [ID_W-1:0]        tx_load_id,
  input  wire logic                   tx_load_ext,
  input  wire logic [DLC_W-1:0]       tx_load_dlc,
  input  wire logic [DATA_W-1:0]      tx_load_data,
  input  wire logic [2*N_TXB-1:0]     transmit_priority_field,
  input  wire logic [N_TXB-1:0]       transmit_request_set,
  input  wire logic [N_TXB-1:0]       transmit_request_clear,
  input  wire logic                   abort_all_bit,
  input  wire logic [N_TXB-1:0]       transmit_done_clear,
  input  wire logic [N_TXB-1:0]       transmit_irq_enable,
  input  wire logic                   bus_free,
  input  wire logic                   tx_ok,
  input  wire logic                   tx_lost,
  input  wire logic                   tx_err_ack,
  input  wire logic                   tx_err_form,
  input  wire logic                   tx_err_bit,
  output logic                        tx_start,
  output logic      [TXB_AW-1:0]      tx_sel,
  output logic      [ID_W-1:0]        tx_id,
  output logic                        tx_ext,
  output logic      [DLC_W-1:0]       tx_dlc,
  output logic      [DATA_W-1:0]      tx_data,
  output logic      [N_RXB-1:0]       receive_done_flag,
  output logic      [N_RXB-1:0]       receive_overrun_flag,
  output logic                        summary_error_flag,
  output logic                        invalid_message_flag,
  output logic                        receive_warning_flag,
  output logic                        receive_passive_flag,
  output logic      [7:0]             receive_error_count,
  output logic      [N_TXB-1:0]       transmit_request_bit,
  output logic      [N_TXB-1:0]       transmit_aborted_flag,
  output logic      [N_TXB-1:0]       lost_arbitration_flag,
  output logic      [N_TXB-1:0]       transmit_error_flag,
  output logic      [N_TXB-1:0]       transmit_done_flag,
  output logic                        transmit_warning_flag,
  output logic                        transmit_passive_flag,
  output logic                        bus_off_flag,
  output logic      [8:0]             transmit_error_count,
  output logic                        irq_receive,
  output logic                        irq_transmit,
  output logic                        irq_error
);

  // Assembly buffer: holds the frame one cycle while filters decide
  logic               asm_valid_ff, nxt_asm_valid;
  logic [ENTRY_W-1:0] asm_entry_ff, nxt_asm_entry;
  logic               asm_ext;
  logic [ID_W-1:0]    asm_id;
  logic [N_FILT-1:0]  filt_hit;
  logic               hit0, hit1;

  always_comb begin
    nxt_asm_valid = rx_frame_valid;
    nxt_asm_entry = asm_entry_ff;
    if (rx_frame_valid) begin
      nxt_asm_entry = {received_ext_id_bit, rx_dlc, rx_id, rx_data};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      asm_valid_ff <= 1'b0;
      asm_entry_ff <= '0;
    end else if (clk_en) begin
      asm_valid_ff <= nxt_asm_valid;
      asm_entry_ff <= nxt_asm_entry;
    end
  end

  assign asm_ext = asm_entry_ff[ENTRY_W-1];
  assign asm_id  = asm_entry_ff[DATA_W +: ID_W];

  for (genvar gi = 0; gi < N_FILT; gi++) begin : g_filt
    logic [ID_W-1:0] msk;
    logic [ID_W-1:0] care;
    assign msk  = (gi < N_FILT0) ? accept_mask_zero : accept_mask_one;
    assign care = asm_ext ? msk : (msk & STD_ID_CARE);
    assign filt_hit[gi] = (filter_ext_select[gi] == asm_ext) &&
      (((asm_id ^ accept_filter_id[gi*ID_W +: ID_W]) & care) == '0);
  end

  assign hit0 = |filt_hit[N_FILT0-1:0];
  assign hit1 = |filt_hit[N_FILT-1:N_FILT0];

  // Receive buffers, flags and error counter
  logic [N_RXB-1:0] full_ff, nxt_full, ovr_ff, nxt_ovr, ovr_set, wr_hot;
  logic             rx_wr_en, rx_wr_addr;
  logic             inval_ff, nxt_inval, summ_ff, nxt_summ;
  logic             rwarn_ff, nxt_rwarn, rpass_ff, nxt_rpass;
  logic [7:0]       rcnt_ff, nxt_rcnt;
  logic [8:0]       rsum;
  logic             rx_any_err, tx_err_evt;
  logic             irq_rx_ff, nxt_irq_rx, irq_err_ff, nxt_irq_err;
  logic [ENTRY_W-1:0] rx_rd_entry;

  always_comb begin
    rx_wr_en   = 1'b0;
    rx_wr_addr = 1'b0;
    ovr_set    = '0;
    if (asm_valid_ff) begin
      if (hit0) begin
        if (!full_ff[0]) begin
          rx_wr_en = 1'b1;
        end else if (double_buffer_enable && !full_ff[1]) begin
          rx_wr_en   = 1'b1;
          rx_wr_addr = 1'b1;
        end else if (double_buffer_enable) begin
          ovr_set[1] = 1'b1;
        end else begin
          ovr_set[0] = 1'b1;
        end
      end else if (hit1) begin
        if (!full_ff[1]) begin
          rx_wr_en   = 1'b1;
          rx_wr_addr = 1'b1;
        end else begin
          ovr_set[1] = 1'b1;
        end
      end
    end
    wr_hot   = {rx_wr_en & rx_wr_addr, rx_wr_en & ~rx_wr_addr};
    nxt_full = (full_ff & ~receive_done_clear) | wr_hot;
    nxt_ovr  = (ovr_ff & ~overrun_clear) | ovr_set;
    rx_any_err = rx_err_crc | rx_err_stuff | rx_err_invalid;
    rsum = {1'b0, rcnt_ff} + {8'h00, rx_err_crc}
         + {8'h00, rx_err_stuff} + {8'h00, rx_err_invalid};
    nxt_rcnt  = (rsum > {1'b0, RX_CNT_MAX}) ? RX_CNT_MAX : rsum[7:0];
    nxt_rwarn = nxt_rcnt >= RX_WARN_LIMIT;
    nxt_rpass = nxt_rcnt > RX_PASS_LIMIT;
    nxt_inval = (inval_ff & ~error_flag_clear) | rx_any_err;
    nxt_summ  = (summ_ff & ~error_flag_clear) | (|ovr_set) | rx_any_err
              | (nxt_rwarn & ~rwarn_ff) | (nxt_rpass & ~rpass_ff)
              | tx_err_evt;
    nxt_irq_rx  = |(nxt_full & receive_irq_enable);
    nxt_irq_err = nxt_summ;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      full_ff    <= '0;
      ovr_ff     <= '0;
      inval_ff   <= 1'b0;
      summ_ff    <= 1'b0;
      rwarn_ff   <= 1'b0;
      rpass_ff   <= 1'b0;
      rcnt_ff    <= RX_CNT_RST;
      irq_rx_ff  <= 1'b0;
      irq_err_ff <= 1'b0;
    end else if (clk_en) begin
      full_ff    <= nxt_full;
      ovr_ff     <= nxt_ovr;
      inval_ff   <= nxt_inval;
      summ_ff    <= nxt_summ;
      rwarn_ff   <= nxt_rwarn;
      rpass_ff   <= nxt_rpass;
      rcnt_ff    <= nxt_rcnt;
      irq_rx_ff  <= nxt_irq_rx;
      irq_err_ff <= nxt_irq_err;
    end
  end

  can_msg_ram #(.W(ENTRY_W), .D(N_RXB), .AW(1)) u_rx_ram (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clk_en  (clk_en),
    .wr_en   (rx_wr_en),
    .wr_addr (rx_wr_addr),
    .wr_data (asm_entry_ff),
    .rd_en   (rd_req),
    .rd_addr (rd_sel),
    .rd_data (rx_rd_entry)
  );

  // Transmit scheduling; each entry holds ext bit, DLC, identifier and data (98 bits)
  tx_state_e          state_ff, nxt_state;
  logic [TXB_AW-1:0]  cur_ff, nxt_cur, pick;
  logic [N_TXB-1:0]   req_ff, nxt_req, abt_ff, nxt_abt, larb_ff, nxt_larb;
  logic [N_TXB-1:0]   terr_ff, nxt_terr, tdone_ff, nxt_tdone;
  logic [N_TXB-1:0]   apend_ff, nxt_apend, abort_req, pend, cur_hot, kill;
  logic               start_ff, nxt_start, tx_rd_en, tx_wr_en, found;
  logic [1:0]         best;
  logic [8:0]         tcnt_ff, nxt_tcnt;
  logic [9:0]         tsum;
  logic               twarn_ff, nxt_twarn, tpass_ff, nxt_tpass;
  logic               boff_ff, nxt_boff, tx_fail, irq_tx_ff, nxt_irq_tx;
  logic [ENTRY_W-1:0] tx_rd_entry;

  assign tx_wr_en = tx_load && (tx_load_sel < TXB_AW'(N_TXB))
                 && !req_ff[tx_load_sel];

  always_comb begin
    nxt_state = state_ff;
    nxt_cur   = cur_ff;
    nxt_start = 1'b0;
    tx_rd_en  = 1'b0;
    nxt_req   = req_ff | transmit_request_set;
    nxt_abt   = abt_ff & ~transmit_request_set;
    nxt_larb  = larb_ff & ~transmit_request_set;
    nxt_terr  = terr_ff & ~transmit_request_set;
    nxt_tdone = tdone_ff & ~transmit_done_clear;
    nxt_apend = apend_ff;
    abort_req = transmit_request_clear | {N_TXB{abort_all_bit}};
    cur_hot   = N_TXB'(1) << cur_ff;
    tx_fail   = tx_lost | tx_err_ack | tx_err_form | tx_err_bit;
    pend      = req_ff & ~abort_req;
    found = 1'b0;
    best  = 2'b00;
    pick  = '0;
    for (int i = 0; i < N_TXB; i++) begin
      if (pend[i] && (!found || transmit_priority_field[2*i +: 2] >= best))
      begin
        found = 1'b1;
        best  = transmit_priority_field[2*i +: 2];
        pick  = TXB_AW'(i);
      end
    end
    case (state_ff)
      T_IDLE: begin
        kill      = abort_req & req_ff;
        nxt_req   = nxt_req & ~kill;
        nxt_abt   = nxt_abt | kill;
        nxt_apend = '0;
        if (bus_free && found && !boff_ff) begin
          tx_rd_en  = 1'b1;
          nxt_cur   = pick;
          nxt_start = 1'b1;
          nxt_state = T_BUSY;
        end
      end
      T_BUSY: begin
        kill      = abort_req & req_ff & ~cur_hot;
        nxt_req   = nxt_req & ~kill;
        nxt_abt   = nxt_abt | kill;
        nxt_apend = apend_ff | (abort_req & cur_hot);
        if (tx_ok) begin
          nxt_req   = nxt_req & ~cur_hot;
          nxt_tdone = nxt_tdone | cur_hot;
          nxt_apend = '0;
          nxt_state = T_IDLE;
        end else if (tx_fail) begin
          if (tx_lost) begin
            nxt_larb = nxt_larb | cur_hot;
          end else begin
            nxt_terr = nxt_terr | cur_hot;
          end
          if (|(nxt_apend & cur_hot)) begin
            nxt_req = nxt_req & ~cur_hot;
            nxt_abt = nxt_abt | cur_hot;
          end
          nxt_apend = '0;
          nxt_state = T_IDLE;
        end
      end
      default: begin
        kill      = '0;
        nxt_state = T_IDLE;
      end
    endcase
    tsum = {1'b0, tcnt_ff} + {9'h000, tx_err_ack}
         + {9'h000, tx_err_form} + {9'h000, tx_err_bit};
    nxt_tcnt  = (tsum > {1'b0, TX_CNT_MAX}) ? TX_CNT_MAX : tsum[8:0];
    nxt_twarn = nxt_tcnt > TX_WARN_LIMIT;
    nxt_tpass = nxt_tcnt > TX_PASS_LIMIT;
    nxt_boff  = nxt_tcnt > TX_BOFF_LIMIT;
    tx_err_evt = (nxt_twarn & ~twarn_ff) | (nxt_tpass & ~tpass_ff)
               | (nxt_boff & ~boff_ff) | (|(nxt_terr & ~terr_ff));
    nxt_irq_tx = |(nxt_tdone & ~nxt_req & transmit_irq_enable);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_ff  <= T_IDLE;
      cur_ff    <= '0;
      start_ff  <= 1'b0;
      req_ff    <= '0;
      abt_ff    <= '0;
      larb_ff   <= '0;
      terr_ff   <= '0;
      tdone_ff  <= '0;
      apend_ff  <= '0;
      tcnt_ff   <= TX_CNT_RST;
      twarn_ff  <= 1'b0;
      tpass_ff  <= 1'b0;
      boff_ff   <= 1'b0;
      irq_tx_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff  <= nxt_state;
      cur_ff    <= nxt_cur;
      start_ff  <= nxt_start;
      req_ff    <= nxt_req;
      abt_ff    <= nxt_abt;
      larb_ff   <= nxt_larb;
      terr_ff   <= nxt_terr;
      tdone_ff  <= nxt_tdone;
      apend_ff  <= nxt_apend;
      tcnt_ff   <= nxt_tcnt;
      twarn_ff  <= nxt_twarn;
      tpass_ff  <= nxt_tpass;
      boff_ff   <= nxt_boff;
      irq_tx_ff <= nxt_irq_tx;
    end
  end

  can_msg_ram #(.W(ENTRY_W), .D(N_TXB), .AW(TXB_AW)) u_tx_ram (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clk_en  (clk_en),
    .wr_en   (tx_wr_en),
    .wr_addr (tx_load_sel),
    .wr_data ({tx_load_ext, tx_load_dlc, tx_load_id, tx_load_data}),
    .rd_en   (tx_rd_en),
    .rd_addr (pick),
    .rd_data (tx_rd_entry)
  );

  assign {rd_ext, rd_dlc, rd_id, rd_data} = rx_rd_entry;
  assign {tx_ext, tx_dlc, tx_id, tx_data} = tx_rd_entry;
  assign tx_start              = start_ff;
  assign tx_sel                = cur_ff;
  assign receive_done_flag     = full_ff;
  assign receive_overrun_flag  = ovr_ff;
  assign summary_error_flag    = summ_ff;
  assign invalid_message_flag  = inval_ff;
  assign receive_warning_flag  = rwarn_ff;
  assign receive_passive_flag  = rpass_ff;
  assign receive_error_count   = rcnt_ff;
  assign transmit_request_bit  = req_ff;
  assign transmit_aborted_flag = abt_ff;
  assign lost_arbitration_flag = larb_ff;
  assign transmit_error_flag   = terr_ff;
  assign transmit_done_flag    = tdone_ff;
  assign transmit_warning_flag = twarn_ff;
  assign transmit_passive_flag = tpass_ff;
  assign bus_off_flag          = boff_ff;
  assign transmit_error_count  = tcnt_ff;
  assign irq_receive           = irq_rx_ff;
  assign irq_transmit          = irq_tx_ff;
  assign irq_error             = irq_err_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_rx_store0;
    clk_en && asm_valid_ff && hit0 && !full_ff[0] |=> full_ff[0];
  endproperty
  a_rx_store0: assert property (p_rx_store0)
    else $error("accepted frame not stored in buffer zero");

  property p_overrun1;
    clk_en && asm_valid_ff && !hit0 && hit1 && full_ff[1]
      |=> ovr_ff[1] && summ_ff;
  endproperty
  a_overrun1: assert property (p_overrun1)
    else $error("overrun on buffer one not flagged");

  property p_no_redirect;
    clk_en && asm_valid_ff && hit0 && full_ff[0] && !double_buffer_enable
      |=> ovr_ff[0] && (!full_ff[1] || $past(full_ff[1]));
  endproperty
  a_no_redirect: assert property (p_no_redirect)
    else $error("buffer zero overrun missing or redirected");

  property p_redirect;
    clk_en && asm_valid_ff && hit0 && full_ff[0] && !full_ff[1]
      && double_buffer_enable |=> full_ff[1] && (ovr_ff[0] == $past(ovr_ff[0])
      || $past(overrun_clear[0]));
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("double buffering did not redirect to buffer one");

  property p_limits;
    (rwarn_ff == (rcnt_ff >= 8'd96)) && (rpass_ff == (rcnt_ff > 8'd127))
      && (boff_ff == (tcnt_ff > 9'd255)) && (tpass_ff == (tcnt_ff > 9'd127));
  endproperty
  a_limits: assert property (p_limits)
    else $error("error state flag disagrees with counter");

  property p_req_set;
    clk_en && state_ff == T_IDLE && transmit_request_set[0]
      && !transmit_request_clear[0] && !abort_all_bit
      |=> req_ff[0] && !abt_ff[0] && !larb_ff[0] && !terr_ff[0];
  endproperty
  a_req_set: assert property (p_req_set)
    else $error("request set did not queue or clear flags");

  property p_success;
    clk_en && state_ff == T_BUSY && tx_ok && cur_ff == 2'd1
      && !transmit_request_set[1] |=> !req_ff[1] && tdone_ff[1];
  endproperty
  a_success: assert property (p_success)
    else $error("successful send left request pending");

  property p_top_prio;
    clk_en && state_ff == T_IDLE && bus_free && !boff_ff && req_ff[2]
      && transmit_priority_field[5:4] == 2'b11 && !abort_all_bit
      && !transmit_request_clear[2] |=> tx_start && tx_sel == 2'd2 ##1 !tx_start;
  endproperty
  a_top_prio: assert property (p_top_prio)
    else $error("highest priority buffer not started");

  property p_abort_all;
    clk_en && state_ff == T_IDLE && abort_all_bit && req_ff[0]
      && !transmit_request_set[0] |=> !req_ff[0] && abt_ff[0]
      && tdone_ff[0] == $past(tdone_ff[0]);
  endproperty
  a_abort_all: assert property (p_abort_all)
    else $error("abort-all did not abort idle buffer");

endmodule

// >>> test/can_engine_model.sv
/*
  Stand-in for the protocol engine on the bus side of the buffer block.
  Assumes tx_start pulses from the block on clk_sys.
*/
`timescale 1ns/1ps
module can_engine_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       tx_start,
  input  wire logic [1:0] mode,
  input  wire logic       slow,
  output logic            bus_free,
  output logic [4:0]      outcome
);
  logic [4:0] cnt;
  logic [1:0] kind;

  // Outcome order: ok, lost, ack error, form error, bit error
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt <= 5'h00;
      kind <= 2'h0;
      outcome <= 5'h00;
      bus_free <= 1'b1;
    end else begin
      outcome <= 5'h00;
      if (tx_start) begin
        cnt <= slow ? 5'h14 : 5'h02;
        bus_free <= 1'b0;
      end else if (cnt == 5'h01) begin
        cnt <= 5'h00;
        bus_free <= 1'b1;
        kind <= (kind == 2'h2) ? 2'h0 : kind + 2'h1;
        outcome <= (mode == 2'h0) ? 5'h10 :
                   (mode == 2'h1) ? 5'h08 : 5'h04 >> kind;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule

// >>> test/can_message_buffering_test.sv
/*
  Self-checking bench for the message buffering block.
  Assumes can_engine_model on the engine side; one 100 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(A, E) begin \
  checks_done++; \
  if ((A) !== (E)) begin \
    failures++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, A, E); \
  end \
end
`define PULSE(S, V) begin \
  @(posedge clk_sys); \
  S <= V; \
  @(posedge clk_sys); \
  S <= '0; \
end
module can_message_buffering_test import can_buf_pkg::*; ;
  typedef struct packed {
    logic e;
    logic [ID_W-1:0] id;
    logic [1:0] d;
  } row_s;
  int failures = 0;
  int checks_done = 0;
  logic clk_sys = 0, reset = 1, clk_en = 1, slow = 0, rd_sel = 0;
  logic rx_frame_valid = 0, received_ext_id_bit = 0, rd_req = 0;
  logic rx_err_crc = 0, rx_err_stuff = 0, rx_err_invalid = 0;
  logic double_buffer_enable = 0, error_flag_clear = 0, tx_load = 0;
  logic abort_all_bit = 0, tx_start, summary_error_flag, bus_free;
  logic invalid_message_flag, receive_warning_flag, receive_passive_flag;
  logic transmit_warning_flag, transmit_passive_flag, bus_off_flag;
  logic irq_receive, irq_transmit, irq_error;
  logic [1:0] mode = 0, tx_load_sel = 0, tx_sel;
  logic [1:0] receive_done_clear = 0, overrun_clear = 0;
  logic [1:0] receive_irq_enable = 2'h1, receive_done_flag;
  logic [1:0] receive_overrun_flag;
  logic [2:0] transmit_request_set = 0, transmit_request_clear = 0;
  logic [2:0] transmit_done_clear = 0, transmit_irq_enable = 3'h7;
  logic [2:0] transmit_request_bit, transmit_aborted_flag;
  logic [2:0] lost_arbitration_flag, transmit_error_flag;
  logic [2:0] transmit_done_flag;
  logic [4:0] oc;
  logic [5:0] filter_ext_select = 6'h04;
  logic [5:0] transmit_priority_field = 6'h31;
  logic [7:0] receive_error_count;
  logic [8:0] transmit_error_count;
  logic [ID_W-1:0] rx_id = 0, tx_load_id = 0, rd_id, tx_id;
  logic [ID_W-1:0] accept_mask_zero = 29'h1FFBFFFF;
  logic [ID_W-1:0] accept_mask_one = 29'h1FFFFFFF;
  logic [N_FILT*ID_W-1:0] accept_filter_id =
    {87'h0, 29'h0ABCDEF, 11'h7FF, 18'h0, 11'h123, 18'h0};
  row_s rows [6] = '{{1'h0, 11'h123, 18'h0, 2'h1},
    {1'h0, 11'h122, 18'h3, 2'h1}, {1'h0, 11'h133, 18'h0, 2'h0},
    {1'h1, 11'h123, 18'h0, 2'h0}, {1'h1, 29'h0ABCDEF, 2'h2},
    {1'h0, 29'h0ABCDEF, 2'h0}};
  int c;

  can_msg_buffer dut_u (.*, .rx_dlc(rx_id[3:0]), .rx_data({35'h0, rx_id}),
    .tx_load_ext(tx_load_id[0]), .tx_load_dlc(tx_load_id[3:0]),
    .tx_load_data({35'h0, tx_load_id}), .tx_ok(oc[4]), .tx_lost(oc[3]),
    .tx_err_ack(oc[2]), .tx_err_form(oc[1]), .tx_err_bit(oc[0]),
    .rd_ext(), .rd_dlc(), .rd_data(), .tx_ext(), .tx_dlc(), .tx_data());
  can_engine_model eng_u (.clk_sys, .reset, .tx_start, .mode, .slow,
    .bus_free, .outcome(oc));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task tk(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task rx(logic e, logic [ID_W-1:0] id);
    @(posedge clk_sys);
    rx_frame_valid <= 1;
    received_ext_id_bit <= e;
    rx_id <= id;
    @(posedge clk_sys);
    rx_frame_valid <= 0;
    tk(3);
  endtask

  task ld(logic [1:0] s);
    @(posedge clk_sys);
    tx_load <= 1;
    tx_load_sel <= s;
    tx_load_id <= {27'h0, s} + 29'h1;
    @(posedge clk_sys);
    tx_load <= 0;
  endtask

  // Waits for bus release (f=1) or for the next start of any buffer, then checks it is buffer s
  task wt(bit f, logic [1:0] s);
    int i;
    for (i = 0; i < 400; i++) begin
      tk(1);
      if ((f ? bus_free : tx_start) === 1'b1) break;
    end
    if (i == 400) begin
      failures++;
      end_of_test;
    end
    if (f) tk(4);
    else `CHK(tx_sel, s)
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 0;
    tk(1);
    `CHK({receive_done_flag, transmit_request_bit, irq_transmit},
      6'h0)
    foreach (rows[i]) begin
      rx(rows[i].e, rows[i].id);
      `CHK(receive_done_flag, rows[i].d)
      `CHK(irq_receive, rows[i].d[0])
      `PULSE(receive_done_clear, 2'h3)
      tk(1);
      `CHK(receive_done_flag, 2'h0)
    end
    $display("test filters done");
    rx(0, {11'h123, 18'h0});
    rx(0, {11'h122, 18'h0});
    `CHK({receive_done_flag, receive_overrun_flag, summary_error_flag},
      5'h0B)
    `PULSE(rd_req, 1'h1)
    tk(1);
    `CHK(rd_id, {11'h123, 18'h0})
    @(posedge clk_sys);
    overrun_clear <= 2'h3;
    error_flag_clear <= 1;
    double_buffer_enable <= 1;
    @(posedge clk_sys);
    overrun_clear <= 2'h0;
    error_flag_clear <= 0;
    rx(0, {11'h123, 18'h0});
    `CHK({receive_done_flag, receive_overrun_flag}, 4'hC)
    rx(0, {11'h123, 18'h0});
    `CHK({receive_done_flag, receive_overrun_flag}, 4'hE)
    `PULSE(overrun_clear, 2'h2)
    rx(1, 29'h0ABCDEF);
    `CHK(receive_overrun_flag, 2'h2)
    $display("test overrun done");
    for (int i = 1; i <= 128; i++) begin
      @(posedge clk_sys);
      {rx_err_crc, rx_err_stuff, rx_err_invalid} <= 3'h4 >> (i % 3);
      @(posedge clk_sys);
      {rx_err_crc, rx_err_stuff, rx_err_invalid} <= 3'h0;
      tk(2);
      `CHK({receive_warning_flag, receive_passive_flag, receive_error_count},
        {i >= 96, i > 127, 8'(i)})
    end
    `CHK({invalid_message_flag, irq_error}, 2'h3)
    $display("test receive errors done");
    ld(0);
    ld(2);
    @(posedge clk_sys);
    mode <= 2'h1;
    slow <= 1;
    `PULSE(transmit_request_set, 3'h5)
    wt(0, 2'h2);
    `CHK(tx_id, 29'h3)
    wt(1, 2'h0);
    `CHK({transmit_request_bit, lost_arbitration_flag, irq_transmit},
      7'h58)
    `CHK(tx_sel, 2'h2)
    @(posedge clk_sys);
    mode <= 2'h0;
    wt(1, 2'h0);
    `CHK({transmit_request_bit, transmit_done_flag, irq_transmit},
      7'h19)
    `CHK(tx_sel, 2'h0)
    @(posedge clk_sys);
    mode <= 2'h2;
    `PULSE(abort_all_bit, 1'h1)
    wt(1, 2'h0);
    `CHK({transmit_request_bit, transmit_aborted_flag, transmit_error_flag,
      transmit_done_flag}, 12'h04C)
    `CHK(transmit_error_count, 9'h001)
    @(posedge clk_sys);
    mode <= 2'h0;
    `PULSE(transmit_request_set, 3'h1)
    wt(0, 2'h0);
    `CHK({transmit_aborted_flag, transmit_error_flag}, 6'h00)
    wt(1, 2'h0);
    `CHK(transmit_request_bit, 3'h0)
    ld(1);
    @(posedge clk_sys);
    transmit_priority_field <= 6'h0F;
    `PULSE(transmit_request_set, 3'h3)
    wt(0, 2'h1);
    `PULSE(transmit_request_clear, 3'h1)
    tk(1);
    `CHK({transmit_request_bit, transmit_aborted_flag}, 6'h11)
    wt(1, 2'h0);
    $display("test transmit done");
    @(posedge clk_sys);
    mode <= 2'h2;
    `PULSE(transmit_request_set, 3'h1)
    c = 1;
    for (int k = 0; k < 20000 && c < 256; k++) begin
      tk(1);
      if (transmit_error_count !== 9'(c)) begin
        c++;
        `CHK(transmit_error_count, 9'(c))
        tk(2);
        `CHK({transmit_warning_flag, transmit_passive_flag, bus_off_flag},
          {c > 96, c > 127, c > 255})
      end
    end
    `CHK(transmit_error_count, 9'h100)
    `PULSE(abort_all_bit, 1'h1)
    tk(1);
    `CHK({transmit_request_bit, transmit_aborted_flag}, 6'h01)
    $display("test bus off done");
    end_of_test;
  end
endmodule
